// ===== logic/his_host_select.sv
// Purpose: Picks the host interface from straps and routes shared pins.
// Assumes: Pins are asynchronous to clk_i; bench link clock 400 ns.
// Notes: Pins are sampled at 20 MHz, so SPI near 4 MHz is marginal.
// Contract
// - Two-wire mode: shared pins form a slave bus up to 400 kHz.
// - Four-wire mode: pins are MOSI, MISO, SCK, nSS up to 4 MHz.
// - LIN mode would use RX, TX and transceiver enable on interrupt.
// - Both straps are sampled once after power-on or reset.
// - In SPI mode the select strap pin becomes the MISO driver.
// - Slave address is 0x66 with address strap low, 0x67 when high.
// - SPI works with nSS grounded when the device is sole slave.
// - SPI mode 0: sample on rising SCK, shift on falling SCK.
// - LIN host mode is not offered; only two-wire and SPI work.
// - Every byte on the SPI link moves MSB first.
// - Interrupt goes low for the first report after start-up time.
module his_host_select
  import his_pkg::*;
#(
  parameter int unsigned READY_CYCLES = HIS_READY_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic slave_serial_data_pin_i,
  output logic slave_serial_data_pin_o,
  output logic slave_serial_data_pin_oe_o,
  input wire logic slave_serial_clock_pin_i,
  input wire logic address_select_strap_i,
  input wire logic interface_select_strap_n_i,
  output logic interface_select_strap_n_o,
  output logic interface_select_strap_n_oe_o,
  output logic host_interrupt_out_n_o,
  input wire logic report_pending_i,
  input wire logic [7:0] tx_byte_i,
  output logic tx_taken_o,
  output logic [7:0] rx_byte_o,
  output logic rx_valid_o,
  output logic [1:0] mode_o,
  output logic ready_o
);
  typedef enum logic [2:0] {
    HIS_I_IDLE,
    HIS_I_ADDR,
    HIS_I_ACK,
    HIS_I_WRITE,
    HIS_I_READ,
    HIS_I_RACK
  } his_i2c_e;

  logic [3:0] s1_ff;
  logic [3:0] s2_ff;
  logic sda_q_ff;
  logic scl_q_ff;
  logic sda;
  logic scl;
  his_mode_e mode_ff;
  logic [6:0] addr_ff;
  logic sampled_ff;
  logic [2:0] settle_ff;
  his_i2c_e ist_ff;
  logic [3:0] bit_ff;
  logic [7:0] sh_ff;
  logic rw_ff;
  logic sda_oe_ff;
  logic i2c_rx_ff;
  logic i2c_tx_ff;
  logic [31:0] ready_cnt_ff;
  logic ready_ff;
  logic hello_ff;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  his_link_if lnk ();

  // Pins: 0 data, 1 clock, 2 address strap, 3 select strap.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_ff <= 4'h0;
      s2_ff <= 4'h0;
      sda_q_ff <= 1'b1;
      scl_q_ff <= 1'b1;
    end else begin
      s1_ff <= {interface_select_strap_n_i, address_select_strap_i,
                slave_serial_clock_pin_i, slave_serial_data_pin_i};
      s2_ff <= s1_ff;
      sda_q_ff <= s2_ff[0];
      scl_q_ff <= s2_ff[1];
    end
  end

  assign sda = s2_ff[0];
  assign scl = s2_ff[1];
  assign scl_rise = scl && !scl_q_ff;
  assign scl_fall = !scl && scl_q_ff;
  assign start_c = scl && scl_q_ff && !sda && sda_q_ff;
  assign stop_c = scl && scl_q_ff && sda && !sda_q_ff;

  // Straps are caught once after the synchronisers have settled and never
  // again, so the select pin may later turn into the MISO driver.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_ff <= HIS_MODE_NONE;
      addr_ff <= HIS_I2C_ADDR_LOW;
      sampled_ff <= 1'b0;
      settle_ff <= 3'h0;
    end else if (!sampled_ff) begin
      settle_ff <= settle_ff + 3'h1;
      if (settle_ff == HIS_STRAP_SETTLE) begin
        sampled_ff <= 1'b1;
        mode_ff <= s2_ff[3] ? HIS_MODE_SPI : HIS_MODE_I2C;
        addr_ff <= s2_ff[2] ? HIS_I2C_ADDR_HIGH : HIS_I2C_ADDR_LOW;
      end
    end
  end

  // Two-wire slave; the device never stretches the clock.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ist_ff <= HIS_I_IDLE;
      bit_ff <= 4'h0;
      sh_ff <= 8'h00;
      rw_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      i2c_rx_ff <= 1'b0;
      i2c_tx_ff <= 1'b0;
    end else begin
      i2c_rx_ff <= 1'b0;
      i2c_tx_ff <= 1'b0;
      if (mode_ff != HIS_MODE_I2C || stop_c) begin
        ist_ff <= HIS_I_IDLE;
        sda_oe_ff <= 1'b0;
      end else if (start_c) begin
        ist_ff <= HIS_I_ADDR;
        bit_ff <= 4'h0;
        sda_oe_ff <= 1'b0;
      end else if (scl_rise) begin
        if ((ist_ff == HIS_I_ADDR || ist_ff == HIS_I_WRITE) &&
            bit_ff < HIS_BITS_PER_BYTE) begin
          sh_ff <= {sh_ff[6:0], sda};
          bit_ff <= bit_ff + 4'h1;
        end else if (ist_ff == HIS_I_RACK && sda) begin
          ist_ff <= HIS_I_IDLE;
        end
      end else if (scl_fall) begin
        case (ist_ff)
          HIS_I_ADDR: begin
            if (bit_ff == HIS_BITS_PER_BYTE) begin
              if (sh_ff[7:1] == addr_ff) begin
                sda_oe_ff <= 1'b1;
                rw_ff <= sh_ff[0];
                ist_ff <= HIS_I_ACK;
              end else begin
                ist_ff <= HIS_I_IDLE;
              end
            end
          end
          HIS_I_WRITE: begin
            if (bit_ff == HIS_BITS_PER_BYTE) begin
              sda_oe_ff <= 1'b1;
              i2c_rx_ff <= 1'b1;
              ist_ff <= HIS_I_ACK;
            end
          end
          HIS_I_ACK, HIS_I_RACK: begin
            if (rw_ff) begin
              sh_ff <= {tx_byte_i[6:0], 1'b0};
              sda_oe_ff <= !tx_byte_i[7];
              i2c_tx_ff <= 1'b1;
              bit_ff <= 4'h1;
              ist_ff <= HIS_I_READ;
            end else begin
              sda_oe_ff <= 1'b0;
              bit_ff <= 4'h0;
              ist_ff <= HIS_I_WRITE;
            end
          end
          HIS_I_READ: begin
            if (bit_ff < HIS_BITS_PER_BYTE) begin
              sda_oe_ff <= !sh_ff[7];
              sh_ff <= {sh_ff[6:0], 1'b0};
              bit_ff <= bit_ff + 4'h1;
            end else begin
              sda_oe_ff <= 1'b0;
              ist_ff <= HIS_I_RACK;
            end
          end
          default: begin
            sda_oe_ff <= 1'b0;
          end
        endcase
      end
    end
  end

  assign lnk.sck = s2_ff[0];
  assign lnk.nss = s2_ff[1];
  assign lnk.mosi = s2_ff[2];
  assign lnk.en = mode_ff == HIS_MODE_SPI;
  assign lnk.tx_byte = tx_byte_i;

  his_spi_slave u_spi (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .lnk(lnk)
  );

  // Pin routing and user-side strobes, all from flip-flops.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      slave_serial_data_pin_o <= 1'b0;
      slave_serial_data_pin_oe_o <= 1'b0;
      interface_select_strap_n_o <= 1'b0;
      interface_select_strap_n_oe_o <= 1'b0;
      rx_byte_o <= 8'h00;
      rx_valid_o <= 1'b0;
      tx_taken_o <= 1'b0;
      mode_o <= 2'h0;
    end else begin
      slave_serial_data_pin_o <= 1'b0;
      slave_serial_data_pin_oe_o <= sda_oe_ff && mode_ff == HIS_MODE_I2C;
      interface_select_strap_n_o <= lnk.miso;
      interface_select_strap_n_oe_o <= lnk.en && !lnk.nss;
      rx_valid_o <= i2c_rx_ff || lnk.rx_valid;
      rx_byte_o <= lnk.rx_valid ? lnk.rx_byte : sh_ff;
      tx_taken_o <= i2c_tx_ff || lnk.tx_taken;
      mode_o <= mode_ff;
    end
  end

  // The interrupt carries a start-up greeting first; the host clears it by
  // starting a two-wire read or completing an SPI byte while selected, after which it follows pending reports.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ready_cnt_ff <= 32'h0;
      ready_ff <= 1'b0;
      hello_ff <= 1'b1;
      host_interrupt_out_n_o <= 1'b1;
      ready_o <= 1'b0;
    end else begin
      if (!ready_ff) begin
        ready_cnt_ff <= ready_cnt_ff + 32'h1;
        ready_ff <= ready_cnt_ff == 32'(READY_CYCLES - 1);
      end
      if (i2c_tx_ff || lnk.tx_taken) begin
        hello_ff <= 1'b0;
      end
      host_interrupt_out_n_o <= !(ready_ff && (hello_ff || report_pending_i));
      ready_o <= ready_ff;
    end
  end

  a_mode_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(sampled_ff) |-> $stable(mode_ff) && $stable(addr_ff))
    else $error("Interface choice moved after sampling.");
  a_strap_take: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(sampled_ff) |-> mode_ff ==
      ($past(s2_ff[3]) ? HIS_MODE_SPI : HIS_MODE_I2C))
    else $error("Mode does not follow the select strap.");
  a_addr_value: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(sampled_ff) |-> addr_ff ==
      ($past(s2_ff[2]) ? HIS_I2C_ADDR_HIGH : HIS_I2C_ADDR_LOW))
    else $error("Slave address does not follow its strap.");
  a_addr_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    ist_ff == HIS_I_ADDR && scl_fall && !start_c && !stop_c &&
    bit_ff == HIS_BITS_PER_BYTE |=>
      sda_oe_ff == ($past(sh_ff[7:1]) == addr_ff) ##1
      slave_serial_data_pin_oe_o == $past(sda_oe_ff))
    else $error("Acknowledge does not match address.");
  a_miso_owner: assert property (@(posedge clk_i) disable iff (rst_i)
    interface_select_strap_n_oe_o |-> mode_o == HIS_MODE_SPI)
    else $error("Select pin driven outside SPI mode.");
  a_sda_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_o == HIS_MODE_SPI |-> !slave_serial_data_pin_oe_o)
    else $error("Data pin driven in SPI mode.");
  a_no_lin: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_ff != HIS_MODE_LIN)
    else $error("LIN mode reached.");
  a_irq_ready: assert property (@(posedge clk_i) disable iff (rst_i)
    !ready_ff ##1 !ready_ff |-> host_interrupt_out_n_o)
    else $error("Interrupt before start-up time.");
endmodule

// ===== include/his_pkg.sv
// Purpose: Shared constants and types for the host interface selector.
// Assumes: Core clock of 20 MHz drives every flip-flop.
// Notes: Link rates are kept as limits the sampling logic must honour.
package his_pkg;
  localparam int unsigned HIS_CLK_HZ = 20000000;
  localparam int unsigned HIS_I2C_MAX_HZ = 400000;
  localparam int unsigned HIS_SPI_MAX_HZ = 4000000;
  localparam int unsigned HIS_LIN_MAX_BAUD = 20000;
  localparam logic [6:0] HIS_I2C_ADDR_LOW = 7'h66;
  localparam logic [6:0] HIS_I2C_ADDR_HIGH = 7'h67;
  localparam logic [2:0] HIS_STRAP_SETTLE = 3'h4;
  localparam int unsigned HIS_READY_TIME_MS = 110;
  localparam longint unsigned HIS_READY_CYCLES_L =
    (64'(HIS_CLK_HZ) * 64'(HIS_READY_TIME_MS)) / 64'd1000;
  localparam int unsigned HIS_READY_CYCLES = int'(HIS_READY_CYCLES_L);
  localparam logic [3:0] HIS_BITS_PER_BYTE = 4'h8;
  localparam logic [2:0] HIS_SPI_LAST_BIT = 3'h7;

  typedef enum logic [1:0] {
    HIS_MODE_NONE,
    HIS_MODE_I2C,
    HIS_MODE_SPI,
    HIS_MODE_LIN
  } his_mode_e;
endpackage

// ===== include/his_link_if.sv
// Purpose: Carries synchronised serial pins and bytes to the serial slave.
// Assumes: All members are on clk_i.
// Notes: Pin levels arrive already through two flip-flops.
interface his_link_if;
  logic sck;
  logic mosi;
  logic nss;
  logic en;
  logic miso;
  logic [7:0] tx_byte;
  logic [7:0] rx_byte;
  logic rx_valid;
  logic tx_taken;
  modport core (output sck, mosi, nss, en, tx_byte,
                input miso, rx_byte, rx_valid, tx_taken);
  modport spi (input sck, mosi, nss, en, tx_byte,
               output miso, rx_byte, rx_valid, tx_taken);
endinterface

// ===== logic/his_spi_slave.sv
// Purpose: Mode 0 serial slave, one byte at a time, MSB first.
// Assumes: Link pins are synchronised by the caller.
// Notes: Byte framing survives a select line tied low permanently.
module his_spi_slave
  import his_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  his_link_if.spi lnk
);
  logic sck_q_ff;
  logic [2:0] cnt_ff;
  logic [7:0] rx_sh_ff;
  logic [7:0] tx_sh_ff;
  logic rx_valid_ff;
  logic tx_taken_ff;
  logic [7:0] rx_byte_ff;
  logic active;
  logic rise;
  logic fall;

  assign active = lnk.en && !lnk.nss;
  assign rise = lnk.sck && !sck_q_ff;
  assign fall = !lnk.sck && sck_q_ff;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sck_q_ff <= 1'b0;
    end else begin
      sck_q_ff <= lnk.sck;
    end
  end

  // Incoming bits are taken on the rising edge, first bit in is the MSB.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_ff <= 3'h0;
      rx_sh_ff <= 8'h00;
      rx_valid_ff <= 1'b0;
      rx_byte_ff <= 8'h00;
    end else begin
      rx_valid_ff <= 1'b0;
      if (!active) begin
        cnt_ff <= 3'h0;
      end else if (rise) begin
        rx_sh_ff <= {rx_sh_ff[6:0], lnk.mosi};
        cnt_ff <= cnt_ff + 3'h1;
        if (cnt_ff == HIS_SPI_LAST_BIT) begin
          rx_valid_ff <= 1'b1;
          rx_byte_ff <= {rx_sh_ff[6:0], lnk.mosi};
        end
      end
    end
  end

  // Outgoing bits change only on the falling edge; a new byte is loaded
  // on the fall that closes the previous one, so no select edge is needed.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_sh_ff <= 8'h00;
      tx_taken_ff <= 1'b0;
    end else begin
      tx_taken_ff <= 1'b0;
      if (!active) begin
        tx_sh_ff <= lnk.tx_byte;
      end else if (fall) begin
        if (cnt_ff == 3'h0) begin
          tx_sh_ff <= lnk.tx_byte;
          tx_taken_ff <= 1'b1;
        end else begin
          tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
        end
      end
    end
  end

  assign lnk.miso = tx_sh_ff[7];
  assign lnk.rx_byte = rx_byte_ff;
  assign lnk.rx_valid = rx_valid_ff;
  assign lnk.tx_taken = tx_taken_ff;

  a_spi_miso_fall: assert property (@(posedge clk_i) disable iff (rst_i)
    active && $past(active) && $changed(tx_sh_ff[7]) |-> $past(fall))
    else $error("MISO moved without a falling clock edge.");
  a_spi_byte_len: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_valid_ff |-> cnt_ff == 3'h0 && $past(rise))
    else $error("Byte closed at the wrong bit.");
endmodule

// ===== sim/his_host_model.sv
// Purpose: Behavioural host processor that drives the shared host pins.
// Assumes: Tasks are called from the bench just after clk_i edges.
// Notes: SPI clock is 5 cycles low and 3 high, one 400 ns period.
module his_host_model (
  input wire logic clk_i,
  input wire logic spi_sel_i,
  input wire logic addr_sel_i,
  input wire logic dev_sda_i,
  input wire logic dev_sda_oe_i,
  input wire logic dev_sel_i,
  input wire logic dev_sel_oe_i,
  output logic data_pin_o,
  output logic clock_pin_o,
  output logic addr_pin_o,
  output logic sel_pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic drv_data_ff = 1'b1;
  logic drv_clk_ff = 1'b1;
  logic drv_mosi_ff = 1'b0;
  // Open-drain data line: high unless either party pulls it low.
  assign data_pin_o = drv_data_ff & ~(dev_sda_oe_i & ~dev_sda_i);
  assign clock_pin_o = drv_clk_ff;
  assign addr_pin_o = spi_sel_i ? drv_mosi_ff : addr_sel_i;
  // Strap is tied low or pulled high by resistor, never tied to supply.
  assign sel_pin_o = dev_sel_oe_i ? dev_sel_i : spi_sel_i;

  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic set_idle(input logic spi, input logic nss);
    drv_data_ff <= ~spi;
    drv_clk_ff <= nss;
    step(1);
  endtask

  task automatic i2c_start();
    drv_data_ff <= 1'b0;
    step(12);
    drv_clk_ff <= 1'b0;
    step(13);
  endtask

  task automatic i2c_stop();
    drv_data_ff <= 1'b0;
    step(12);
    drv_clk_ff <= 1'b1;
    step(12);
    drv_data_ff <= 1'b1;
    step(26);
  endtask

  task automatic i2c_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      drv_data_ff <= b[i];
      step(12);
      drv_clk_ff <= 1'b1;
      step(25);
      drv_clk_ff <= 1'b0;
      step(13);
    end
    drv_data_ff <= 1'b1;
    step(12);
    drv_clk_ff <= 1'b1;
    step(12);
    ack = ~data_pin_o;
    step(13);
    drv_clk_ff <= 1'b0;
    step(13);
  endtask

  // Select is held low across every whole frame. MOSI toggles on both select and release.
  task automatic spi_select(input logic v);
    drv_clk_ff <= v;
    drv_mosi_ff <= ~drv_mosi_ff;
    step(6);
  endtask

  task automatic spi_byte(input logic [7:0] mo, output logic [7:0] mi);
    for (int i = 7; i >= 0; i--) begin
      drv_mosi_ff <= mo[i];
      step(5);
      mi[i] = sel_pin_o;
      drv_data_ff <= 1'b1;
      step(3);
      drv_data_ff <= 1'b0;
    end
  endtask
endmodule

// ===== sim/host_interface_select_bench.sv
// Purpose: Self-checking bench for the host interface selector.
// Assumes: Start-up delay shortened to READY cycles for a quick run.
// Notes: Expected bytes come from a queue; expected acks from the strapped address.
module host_interface_select_bench;
  import his_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned READY = 50;
  logic clk_i;
  logic rst_i = 1'b1;
  logic spi_sel = 1'b0;
  logic addr_sel = 1'b0;
  logic pending = 1'b0;
  logic [7:0] tx_byte = 8'h00;
  logic data_pin, clock_pin, addr_pin, sel_pin, sda_o, sda_oe, sel_o, sel_oe;
  logic irq_n, tx_taken, rx_valid, ready;
  logic [7:0] rx_byte;
  logic [1:0] mode;
  logic [6:0] boot_addr;
  logic [31:0] seed = 32'h88248091;
  int n_errors = 0;
  int tests_run = 0;
  int n_taken = 0;
  logic [7:0] rx_q[$];
  logic [7:0] exp_q[$];

  his_host_select #(.READY_CYCLES(READY)) u_his_host_select (
    .clk_i(clk_i), .rst_i(rst_i), .slave_serial_data_pin_i(data_pin),
    .slave_serial_data_pin_o(sda_o), .slave_serial_data_pin_oe_o(sda_oe),
    .slave_serial_clock_pin_i(clock_pin), .address_select_strap_i(addr_pin),
    .interface_select_strap_n_i(sel_pin), .interface_select_strap_n_o(sel_o),
    .interface_select_strap_n_oe_o(sel_oe), .host_interrupt_out_n_o(irq_n),
    .report_pending_i(pending), .tx_byte_i(tx_byte), .tx_taken_o(tx_taken),
    .rx_byte_o(rx_byte), .rx_valid_o(rx_valid), .mode_o(mode),
    .ready_o(ready));

  his_host_model u_his_host_model (
    .clk_i(clk_i), .spi_sel_i(spi_sel), .addr_sel_i(addr_sel),
    .dev_sda_i(sda_o), .dev_sda_oe_i(sda_oe), .dev_sel_i(sel_o),
    .dev_sel_oe_i(sel_oe), .data_pin_o(data_pin), .clock_pin_o(clock_pin),
    .addr_pin_o(addr_pin), .sel_pin_o(sel_pin));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (rx_valid === 1'b1) begin
      rx_q.push_back(rx_byte);
    end
    if (tx_taken === 1'b1) begin
      n_taken++;
    end
  end

  function automatic logic [7:0] rand8();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cmp_rx();
    check(rx_q.size(), exp_q.size());
    while (rx_q.size() > 0 && exp_q.size() > 0) begin
      check(rx_q.pop_front(), exp_q.pop_front());
    end
  endtask

  // Straps must be steady from the release of reset until they are caught.
  task automatic boot(input logic spi, input logic adr, input logic nss);
    int n;
    spi_sel <= spi;
    addr_sel <= adr;
    rst_i <= 1'b1;
    u_his_host_model.set_idle(spi, nss);
    repeat (3) @(posedge clk_i);
    check(mode, 2'h0);
    check({irq_n, sda_oe, sel_oe}, 3'h4);
    rx_q.delete();
    exp_q.delete();
    boot_addr = adr ? 7'h67 : 7'h66;
    rst_i <= 1'b0;
    n = 0;
    while (irq_n !== 1'b0 && n < READY + 20) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= READY + 20) begin
      n_errors++;
      complete_run();
    end
    check(n >= READY && n <= READY + 4, 1'b1);
    check(ready, 1'b1);
    check(mode, spi ? 2'h2 : 2'h1);
  endtask

  task automatic i2c_write(input logic [6:0] addr);
    logic [7:0] d;
    logic ack;
    logic hit;
    d = rand8();
    hit = (addr == boot_addr);
    u_his_host_model.i2c_start();
    u_his_host_model.i2c_byte({addr, 1'b0}, ack);
    check(ack, hit);
    if (hit) begin
      exp_q.push_back(d);
    end
    u_his_host_model.i2c_byte(d, ack);
    check(ack, hit);
    u_his_host_model.i2c_stop();
  endtask

  task automatic spi_frame(input int n, input logic framed);
    logic [7:0] mo;
    logic [7:0] mi;
    int t0;
    t0 = n_taken;
    if (framed) begin
      u_his_host_model.spi_select(1'b0);
    end
    for (int i = 0; i < n; i++) begin
      mo = rand8();
      exp_q.push_back(mo);
      u_his_host_model.spi_byte(mo, mi);
      if (framed || i > 0) begin
        check(mi, tx_byte);
      end
    end
    check(sel_oe, 1'b1);
    if (framed) begin
      u_his_host_model.spi_select(1'b1);
      check(sel_oe, 1'b0);
    end
    u_his_host_model.step(8);
    check(n_taken - t0, framed ? n - 1 : n);
    cmp_rx();
  endtask

  initial begin
    boot(1'b0, 1'b0, 1'b1);
    i2c_write(7'h66);
    i2c_write(7'h67);
    spi_sel <= 1'b1;
    addr_sel <= 1'b1;
    u_his_host_model.step(20);
    check(mode, 2'h1);
    i2c_write(7'h66);
    check(sel_oe, 1'b0);
    cmp_rx();
    $display("Test two-wire low address done");
    boot(1'b0, 1'b1, 1'b1);
    i2c_write(7'h67);
    i2c_write(7'h66);
    cmp_rx();
    $display("Test two-wire high address done");
    tx_byte <= rand8();
    boot(1'b1, 1'b0, 1'b1);
    spi_frame(3, 1'b1);
    check(irq_n, 1'b1);
    pending <= 1'b1;
    u_his_host_model.step(4);
    check(irq_n, 1'b0);
    pending <= 1'b0;
    $display("Test framed serial done");
    tx_byte <= rand8();
    boot(1'b1, 1'b1, 1'b0);
    spi_frame(3, 1'b0);
    $display("Test grounded select done");
    complete_run();
  end
endmodule
